// file: rl_bus_ctrl.sv
// Behavioural bus controller that issues commands to the block.
`timescale 1ns/1ns
`default_nettype none
module rl_bus_ctrl (
  input wire logic clk,
  output logic atn,
  output logic ren,
  output logic ifc,
  output logic byte_valid,
  output logic [7:0] data_byte
);
  initial {atn, ren, ifc, byte_valid, data_byte} = 12'h0A5;
  // Attention leads the byte by a cycle; the data lines turn over on the same edge that the strobe drops.
  task automatic cmd(input logic [7:0] b);
    @(posedge clk) atn <= 1'h1;
    @(posedge clk) {byte_valid, data_byte} <= {1'h1, b};
    @(posedge clk) {byte_valid, data_byte} <= {1'h0, ~b};
    repeat (2) @(posedge clk);
    atn <= 1'h0;
  endtask
  task automatic clear_if(input int n);
    @(posedge clk) ifc <= 1'h1;
    repeat (n) @(posedge clk);
    ifc <= 1'h0;
  endtask
  task automatic set_ren(input logic v);
    @(posedge clk) ren <= v;
  endtask
endmodule
`default_nettype wire

// file: rl_cmd_decoder.sv
// Decodes one command byte per accepted strobe while attention is asserted.
`timescale 1ns/1ns
`default_nettype none
module rl_cmd_decoder (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic atn,
  input wire logic byte_valid,
  input wire logic [7:0] data_byte,
  input wire logic [4:0] my_addr,
  rl_cmd_if.dec cmd
);
  rl_pkg::dec_state_t state_reg;
  logic take;

  // A byte is only taken once per strobe, so a held strobe cannot repeat a command.
  assign take = (state_reg == rl_pkg::ST_IDLE) && atn && byte_valid;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= rl_pkg::ST_IDLE;
    end else begin
      unique case (state_reg)
        rl_pkg::ST_IDLE: begin
          if (take) begin
            state_reg <= rl_pkg::ST_CMD;
          end
        end
        rl_pkg::ST_CMD: begin
          state_reg <= rl_pkg::ST_WAIT;
        end
        rl_pkg::ST_WAIT: begin
          if (!byte_valid) begin
            state_reg <= rl_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= rl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd.mla <= 1'b0;
      cmd.mta <= 1'b0;
      cmd.unl <= 1'b0;
      cmd.unt <= 1'b0;
      cmd.llo <= 1'b0;
      cmd.gtl <= 1'b0;
      cmd.dcl <= 1'b0;
    end else begin
      cmd.mla <= take && (data_byte == (rl_pkg::LISTEN_BASE | {3'h0, my_addr}));
      cmd.mta <= take && (data_byte == (rl_pkg::TALK_BASE | {3'h0, my_addr}));
      cmd.unl <= take && (data_byte == rl_pkg::CMD_UNL);
      cmd.unt <= take && (data_byte == rl_pkg::CMD_UNT);
      cmd.llo <= take && (data_byte == rl_pkg::CMD_LLO);
      cmd.gtl <= take && (data_byte == rl_pkg::CMD_GTL);
      cmd.dcl <= take && (data_byte == rl_pkg::CMD_DCL);
    end
  end
endmodule
`default_nettype wire

// file: rl_cmd_if.sv
// Decoded bus command pulses passed from the decoder to the state block.
`timescale 1ns/1ns
`default_nettype none
interface rl_cmd_if;
  logic mla;
  logic mta;
  logic unl;
  logic unt;
  logic llo;
  logic gtl;
  logic dcl;
  modport dec(output mla, mta, unl, unt, llo, gtl, dcl);
  modport core(input mla, mta, unl, unt, llo, gtl, dcl);
endinterface
`default_nettype wire

// file: rl_control.sv
// Remote/local, lockout and talker/listener addressing state of the bus interface.
// How it works
// - Interface clear forces talker idle and listener idle, whatever the addressing was.
// - Interface clear turns off the talk and listen indicators.
// - Lockout disables the LOCAL key so remote cannot be left from the panel.
// - Lockout command takes effect immediately only when already in remote.
// - Remote enable going false cancels lockout and remote; nothing else clears the held lockout command.
// - Go-to-local received while addressed to listen leaves remote mode.
// - Go-to-local restores panel keys even under lockout; the held lockout returns when remote is re-entered.
// - Device clear pulses a request to return all settings to defaults.
// - Device clear defaults come from the slot on setup_slot when the clear arrives; slot 1 until the first clear.
// - Remote is entered only on listen addressing while remote enable is true.
// - In remote all keys but LOCAL are ignored; LOCAL returns local unless locked.
`timescale 1ns/1ns
`default_nettype none
module rl_control #(
  parameter int IFC_CYCLES = rl_pkg::IFC_MIN_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic atn,
  input wire logic ren,
  input wire logic ifc,
  input wire logic byte_valid,
  input wire logic [7:0] data_byte,
  input wire logic [4:0] my_addr,
  input wire logic local_key,
  input wire logic panel_key,
  input wire logic [3:0] setup_slot,
  output logic talk_active,
  output logic listen_active,
  output logic remote,
  output logic lockout,
  output logic local_key_enabled,
  output logic panel_keys_enabled,
  output logic panel_key_accepted,
  output logic device_clear,
  output logic [3:0] default_slot
);
  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  rl_cmd_if cmd_bus();

  rl_cmd_decoder u_dec (
    .clk(clk),
    .reset_n(reset_n),
    .atn(atn),
    .byte_valid(byte_valid),
    .data_byte(data_byte),
    .my_addr(my_addr),
    .cmd(cmd_bus)
  );

  // ---------------------------------------------------------------
  // Interface clear qualification
  // ---------------------------------------------------------------
  // Short glitches on the clear line must not drop the addressing, so the clear
  // acts only once the line has been held for the minimum time.
  logic [$clog2(IFC_CYCLES + 1)-1:0] ifc_cnt_reg;
  logic ifc_done;

  assign ifc_done = ifc && (ifc_cnt_reg == ($bits(ifc_cnt_reg))'(IFC_CYCLES - 1));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ifc_cnt_reg <= '0;
    end else if (!ifc) begin
      ifc_cnt_reg <= '0;
    end else if (ifc_cnt_reg != ($bits(ifc_cnt_reg))'(IFC_CYCLES)) begin
      ifc_cnt_reg <= ifc_cnt_reg + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Talker and listener addressing
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      talk_active <= 1'b0;
    end else if (ifc_done) begin
      talk_active <= 1'b0;
    end else if (cmd_bus.mta) begin
      talk_active <= 1'b1;
    end else if (cmd_bus.unt || cmd_bus.mla) begin
      talk_active <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      listen_active <= 1'b0;
    end else if (ifc_done) begin
      listen_active <= 1'b0;
    end else if (cmd_bus.mla) begin
      listen_active <= 1'b1;
    end else if (cmd_bus.unl || cmd_bus.mta) begin
      listen_active <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Remote and lockout
  // ---------------------------------------------------------------
  logic local_press;

  // LOCAL only counts while not locked out.
  assign local_press = local_key && !lockout;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      remote <= 1'b0;
    end else if (!ren) begin
      remote <= 1'b0;
    end else if (cmd_bus.mla) begin
      remote <= 1'b1;
    end else if (cmd_bus.gtl && listen_active) begin
      remote <= 1'b0;
    end else if (remote && local_press) begin
      remote <= 1'b0;
    end
  end

  // The flag is held even when the command arrives in local mode; it only bites
  // once remote is entered, which is why lockout output is qualified by remote.
  logic llo_flag_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      llo_flag_reg <= 1'b0;
    end else if (!ren) begin
      llo_flag_reg <= 1'b0;
    end else if (cmd_bus.llo) begin
      llo_flag_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lockout <= 1'b0;
    end else begin
      lockout <= ren && (llo_flag_reg || cmd_bus.llo) && remote;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      local_key_enabled <= 1'b1;
      panel_keys_enabled <= 1'b1;
      panel_key_accepted <= 1'b0;
    end else begin
      local_key_enabled <= !lockout;
      panel_keys_enabled <= !remote && !lockout;
      panel_key_accepted <= panel_key && !remote && !lockout;
    end
  end

  // ---------------------------------------------------------------
  // Device clear
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      device_clear <= 1'b0;
      default_slot <= rl_pkg::SETUP_SLOT_DEFAULT;
    end else begin
      device_clear <= cmd_bus.dcl;
      if (cmd_bus.dcl) begin
        default_slot <= setup_slot;
      end
    end
  end
endmodule
`default_nettype wire

// file: rl_control_chk.sv
// Concurrent checks on the ports of the remote/local control block.
`timescale 1ns/1ns
`default_nettype none
module rl_control_chk #(
  parameter int IFC_CYCLES = rl_pkg::IFC_MIN_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ren,
  input wire logic ifc,
  input wire logic byte_valid,
  input wire logic talk_active,
  input wire logic listen_active,
  input wire logic remote,
  input wire logic lockout,
  input wire logic local_key_enabled,
  input wire logic panel_keys_enabled,
  input wire logic panel_key_accepted,
  input wire logic device_clear,
  input wire logic [3:0] default_slot
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Counts how long the clear line has been held, so only clears of the full minimum are checked.
  int ifc_cnt;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      ifc_cnt <= 0;
    else
      ifc_cnt <= ifc ? ifc_cnt + 1 : 0;
  end
  ifc_idle_a: assert property (ifc_cnt >= IFC_CYCLES |-> ##[0:2] (!talk_active && !listen_active))
    else $error("addressing survives a long clear");
  ren_drop_a: assert property ($fell(ren) |=> !remote ##1 (!remote && !lockout))
    else $error("remote or lockout kept after enable fell");
  lock_hold_a: assert property (lockout && remote && ren && !byte_valid && !$past(byte_valid)
    && !$past(byte_valid, 2) |=> remote)
    else $error("remote left while locked out");
  panel_ign_a: assert property (remote |=> !panel_key_accepted)
    else $error("panel key taken in remote");
  remote_entry_a: assert property ($rose(remote) |-> listen_active && $past(ren))
    else $error("remote entered without listen and enable");
  lock_entry_a: assert property ($rose(lockout) |-> $past(remote) && $past(ren))
    else $error("lockout applied outside remote");
  keys_lock_a: assert property (lockout |=> !local_key_enabled && !panel_keys_enabled)
    else $error("keys enabled under lockout");
  clear_pulse_a: assert property (device_clear |=> !device_clear)
    else $error("device clear longer than one cycle");
  slot_latch_a: assert property ($changed(default_slot) |-> device_clear || $past(device_clear))
    else $error("default slot changed without device clear");
endmodule
`default_nettype wire

// file: rl_pkg.sv
// Shared constants and types for the remote/local bus interface block.
package rl_pkg;
  // ---------------------------------------------------------------
  // Bus command bytes and timing
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_GTL = 8'h01;
  localparam logic [7:0] CMD_LLO = 8'h11;
  localparam logic [7:0] CMD_DCL = 8'h14;
  localparam logic [7:0] CMD_UNL = 8'h3F;
  localparam logic [7:0] CMD_UNT = 8'h5F;
  localparam logic [7:0] LISTEN_BASE = 8'h20;
  localparam logic [7:0] TALK_BASE = 8'h40;
  localparam logic [4:0] ADDR_DEFAULT = 5'h0F;
  localparam int CLK_MHZ = 25;
  localparam int IFC_MIN_US = 100;
  localparam int IFC_MIN_CYCLES = IFC_MIN_US * CLK_MHZ;
  localparam logic [3:0] SETUP_SLOT_DEFAULT = 4'h1;
  // ---------------------------------------------------------------
  // Command decoder states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CMD = 3'b010,
    ST_WAIT = 3'b100
  } dec_state_t;
endpackage

// file: tb_rl_control.sv
// Self-checking bench for the remote/local control block.
`timescale 1ns/1ns
`default_nettype none
`define CMP(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("Error t=%0t got %h exp %h", $time, a, e); end end
module tb_rl_control;
  localparam int IFC_CYCLES = 8;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic local_key = 1'h0;
  logic panel_key = 1'h1;
  logic [3:0] setup_slot = 4'h1;
  logic [4:0] my_addr = rl_pkg::ADDR_DEFAULT;
  logic atn, ren, ifc, byte_valid;
  logic [7:0] data_byte;
  logic talk_active, listen_active, remote, lockout, local_key_enabled;
  logic panel_keys_enabled, panel_key_accepted, device_clear;
  logic [3:0] default_slot;
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;
  int seed = 71;
  logic [6:0] q[$];
  logic [3:0] sq[$];
  logic [6:0] exp_word;
  logic [3:0] exp_slot;
  event ev;
  rl_control #(.IFC_CYCLES(IFC_CYCLES)) rl_control_inst (
    .clk(clk),
    .reset_n(reset_n),
    .atn(atn),
    .ren(ren),
    .ifc(ifc),
    .byte_valid(byte_valid),
    .data_byte(data_byte),
    .my_addr(my_addr),
    .local_key(local_key),
    .panel_key(panel_key),
    .setup_slot(setup_slot),
    .talk_active(talk_active),
    .listen_active(listen_active),
    .remote(remote),
    .lockout(lockout),
    .local_key_enabled(local_key_enabled),
    .panel_keys_enabled(panel_keys_enabled),
    .panel_key_accepted(panel_key_accepted),
    .device_clear(device_clear),
    .default_slot(default_slot)
  );
  rl_bus_ctrl rl_bus_ctrl_inst (
    .clk(clk),
    .atn(atn),
    .ren(ren),
    .ifc(ifc),
    .byte_valid(byte_valid),
    .data_byte(data_byte)
  );
  always #20 clk = ~clk;
  // The note is popped once, so a mismatch report cannot eat the next note.
  always @(ev) begin
    #1;
    exp_word = q.pop_front();
    `CMP({talk_active, listen_active, remote, lockout, local_key_enabled,
      panel_keys_enabled, panel_key_accepted}, exp_word)
  end
  always @(posedge clk) begin
    #1;
    if (device_clear === 1'h1) begin
      exp_slot = sq.pop_front();
      `CMP(default_slot, exp_slot)
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic exp(input logic [6:0] v);
    repeat (4) @(posedge clk);
    q.push_back(v);
    -> ev;
  endtask
  task automatic press();
    @(posedge clk) local_key <= 1'h1;
    repeat (2) @(posedge clk);
    local_key <= 1'h0;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'h1;
    exp(7'h07);
    panel_key <= 1'h0;
    exp(7'h06);
    panel_key <= 1'h1;
    rl_bus_ctrl_inst.cmd(8'h2F);
    exp(7'h27);
    rl_bus_ctrl_inst.cmd(8'h4F);
    exp(7'h47);
    rl_bus_ctrl_inst.clear_if(IFC_CYCLES - 1);
    exp(7'h47);
    rl_bus_ctrl_inst.clear_if(IFC_CYCLES);
    exp(7'h07);
    $display("addressing test done");
    rl_bus_ctrl_inst.set_ren(1'h1);
    exp(7'h07);
    rl_bus_ctrl_inst.cmd(8'h2F);
    exp(7'h34);
    press();
    exp(7'h27);
    rl_bus_ctrl_inst.cmd(8'h2F);
    rl_bus_ctrl_inst.cmd(rl_pkg::CMD_LLO);
    exp(7'h38);
    press();
    exp(7'h38);
    rl_bus_ctrl_inst.cmd(rl_pkg::CMD_GTL);
    exp(7'h27);
    rl_bus_ctrl_inst.cmd(8'h2F);
    exp(7'h38);
    rl_bus_ctrl_inst.set_ren(1'h0);
    exp(7'h27);
    rl_bus_ctrl_inst.set_ren(1'h1);
    rl_bus_ctrl_inst.cmd(8'h2F);
    exp(7'h34);
    rl_bus_ctrl_inst.cmd(rl_pkg::CMD_UNL);
    rl_bus_ctrl_inst.cmd(rl_pkg::CMD_GTL);
    exp(7'h14);
    my_addr <= 5'h03;
    rl_bus_ctrl_inst.cmd(8'h2F);
    exp(7'h14);
    rl_bus_ctrl_inst.cmd(rl_pkg::TALK_BASE | 8'h03);
    exp(7'h54);
    rl_bus_ctrl_inst.cmd(rl_pkg::CMD_UNT);
    exp(7'h14);
    $display("remote and lockout test done");
    repeat (3) begin
      @(posedge clk) setup_slot <= 4'($random(seed));
      @(posedge clk) sq.push_back(setup_slot);
      rl_bus_ctrl_inst.cmd(rl_pkg::CMD_DCL);
    end
    repeat (4) @(posedge clk);
    `CMP(sq.size(), 0)
    $display("device clear test done");
    stop_test();
  end
endmodule
bind rl_control rl_control_chk #(.IFC_CYCLES(IFC_CYCLES)) rl_control_chk_inst (
  .clk(clk),
  .reset_n(reset_n),
  .ren(ren),
  .ifc(ifc),
  .byte_valid(byte_valid),
  .talk_active(talk_active),
  .listen_active(listen_active),
  .remote(remote),
  .lockout(lockout),
  .local_key_enabled(local_key_enabled),
  .panel_keys_enabled(panel_keys_enabled),
  .panel_key_accepted(panel_key_accepted),
  .device_clear(device_clear),
  .default_slot(default_slot)
);
`default_nettype wire
